//--- sfb_regs.vh
// Constants for the serial flash bus front end: opcodes, pin slots, timing.
`ifndef SFB_REGS_VH
`define SFB_REGS_VH

// Opcodes that the front end acts on.
`define SFB_OP_ENTER_QPI  8'h38
`define SFB_OP_EXIT_QPI   8'hff
`define SFB_OP_RST_ENABLE 8'h66
`define SFB_OP_RST_DO     8'h99
`define SFB_OP_DUAL_OUT   8'h3b
`define SFB_OP_DUAL_IO    8'hbb
`define SFB_OP_QUAD_OUT   8'h6b
`define SFB_OP_QUAD_IO    8'heb
`define SFB_OP_QUAD_WORD  8'he7
`define SFB_OP_QUAD_OCT   8'he3

// Slots of the pin vector that passes the synchronisers.
`define SFB_PIN_SEL   0
`define SFB_PIN_SCLK  1
`define SFB_PIN_LANE0 2
`define SFB_PIN_LANE3 5

// Reset value of the filtered pins: deselected, clock low, lanes low.
`define SFB_PIN_RST 6'h01

// Software reset recovery time and the count of clocks it takes.
`define SFB_CLK_MHZ    25
`define SFB_RST_US     10
`define SFB_RST_CYC    (`SFB_RST_US * `SFB_CLK_MHZ)

// Lane counts per transfer configuration.
`define SFB_LANES_ONE  4'h1
`define SFB_LANES_TWO  4'h2
`define SFB_LANES_FOUR 4'h4

`endif

//--- sfb_flash_bus.v
// Serial flash bus front end with its read data FIFO.
`timescale 1ns/1ps
`include "sfb_regs.vh"

// What this block does
// - Works with a host in clock mode 0 or mode 3 only.
// - Samples lanes on rising clock edges, drives outputs after falling edges.
// - Clock cycles run from falling edge to falling edge.
// - Dual reads 3Bh and BBh use lane0 and lane1, two bits per clock; in four-lane instruction mode they use all four lanes.
// - Quad reads 6Bh, EBh, E7h, E3h use all four lanes.
// - Quad-lane instructions are taken only with four_lane_enable set.
// - 38h enters four-lane instruction mode, FFh leaves it.
// - Opcode takes two clocks on four lanes, eight on serial_in_line.
// - Power-up and software reset leave the device in SPI mode.
// - Entering four-lane instruction mode needs four_lane_enable.
// - Pause works only in standard and dual operation while selected.
// - Pause begins at pin fall with clock low, else next clock fall.
// - Pause ends at pin rise with clock low, else next clock fall.
// - Paused: outputs floated, lanes and clock ignored, state kept.
// - Software reset is 66h then 99h, in either mode.
// - After software reset, about 10us of rejecting every command.
// - pause_or_restart_select picks pause (0) or hardware reset (1).
// - Restart pin low resets the device and refuses all commands.
// - The restart pin overrides select, clock and lane inputs; four_lane_enable set disables it.
// - With four_lane_enable set, the shared pin is only lane3.

////////////////////////////////////////////////////////////////////////
// Read data FIFO between the user side and the serial output shifter.
module sfb_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
)(
	input  wire          clk_in,       // System clock.
	input  wire          rst_n_in,     // Synchronised reset, active low.
	input  wire          wr_valid_in,  // Write word offered.
	input  wire [W-1:0]  wr_data_in,   // Write word.
	output reg           wr_ready_out, // Room for a word.
	output reg           rd_valid_out, // A word is waiting.
	output wire [W-1:0]  rd_data_out,  // Oldest word.
	input  wire          rd_ready_in   // Take the oldest word.
);
	localparam [AW:0] FULL_C = D[AW:0];

	reg  [W-1:0] mem [0:D-1];
	reg  [AW-1:0] wptr_reg;
	reg  [AW-1:0] rptr_reg;
	reg  [AW:0]   count_reg;
	wire          push;
	wire          pop;
	wire [AW:0]   count_next;

	// Handshakes only count while the flags say so, so full never wraps.
	assign push = wr_valid_in & wr_ready_out;
	assign pop = rd_ready_in & rd_valid_out;
	assign count_next = count_reg + {{AW{1'b0}}, push}
		- {{AW{1'b0}}, pop};
	assign rd_data_out = mem[rptr_reg];

	// Storage has no reset; only pointers, count and flags need one.
	always @(posedge clk_in)
	begin
		if (push)
			mem[wptr_reg] <= wr_data_in;
	end

	// Pointers, count and registered flags.
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			wr_ready_out <= 1'b0;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			if (push)
				wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
			count_reg <= count_next;
			wr_ready_out <= (count_next != FULL_C);
			rd_valid_out <= (count_next != {(AW+1){1'b0}});
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Device-side bus interface: pins in, lanes out, opcode decode.
module sfb_flash_bus (
	input  wire       clk_in,             // System clock, 25 MHz.
	input  wire       rstn_in,            // Reset, active low, async.
	input  wire       select_n_in,        // Select pin, active low.
	input  wire       sclk_in,            // Serial clock pin from host.
	input  wire       lane0_in,           // Lane0 / serial_in_line.
	input  wire       lane1_in,           // Lane1 input.
	input  wire       lane2_in,           // Lane2 / write guard input.
	input  wire       lane3_in,           // Lane3 / pause or restart.
	output reg        lane0_out,          // Lane0 drive value.
	output reg        lane1_out,          // Lane1 drive value.
	output reg        lane2_out,          // Lane2 drive value.
	output reg        lane3_out,          // Lane3 drive value.
	output reg        lane0_oe_out,       // Lane0 driven when high.
	output reg        lane1_oe_out,       // Lane1 driven when high.
	output reg        lane2_oe_out,       // Lane2 driven when high.
	output reg        lane3_oe_out,       // Lane3 driven when high.
	input  wire       four_lane_enable_in, // Quad enable status bit.
	input  wire       pause_or_restart_select_in, // 0 pause, 1 restart.
	input  wire       data_valid_in,      // Read byte offered.
	input  wire [7:0] data_in,            // Read byte.
	output wire       data_ready_out,     // FIFO has room.
	output reg  [7:0] cmd_out,            // Last accepted opcode.
	output reg        cmd_valid_out,      // Pulse: opcode accepted.
	output reg        qpi_mode_out,       // Four-lane instruction mode.
	output reg        busy_out            // Commands are refused.
);
	localparam [2:0] ST_CMD = 3'b001;
	localparam [2:0] ST_DATA = 3'b010;
	localparam [2:0] ST_SKIP = 3'b100;
	localparam integer RST_CYC_I = `SFB_RST_CYC;
	localparam [8:0] RST_CYC_C = RST_CYC_I[8:0];

	// Shift left by the lane count, filling from the lane inputs.
	function [7:0] sfb_shl;
		input [7:0] val;
		input [3:0] ins;
		input [3:0] lanes;
		begin
			case (lanes)
				`SFB_LANES_TWO: sfb_shl = {val[5:0], ins[1:0]};
				`SFB_LANES_FOUR: sfb_shl = {val[3:0], ins};
				default: sfb_shl = {val[6:0], ins[0]};
			endcase
		end
	endfunction

	reg  [1:0] rst_sync_reg;
	wire       rst_n;
	reg  [5:0] s1_reg;
	reg  [5:0] s2_reg;
	reg  [5:0] s3_reg;
	reg  [5:0] filt_reg;
	reg  [5:0] prev_reg;
	reg  [2:0] state_reg;
	reg  [7:0] in_sh_reg;
	reg  [3:0] in_cnt_reg;
	reg  [7:0] out_sh_reg;
	reg  [3:0] out_cnt_reg;
	reg  [3:0] lanes_reg;
	reg        drive_reg;
	reg        paused_reg;
	reg        armed_reg;
	reg  [8:0] timer_reg;
	wire [3:0] lane_pins;
	wire       sel;
	wire       rise;
	wire       fall;
	wire       hw_rst;
	wire       pause_ok;
	wire [3:0] cmd_lanes;
	wire [7:0] op_next;
	wire [3:0] in_cnt_next;
	wire       pop;
	wire       fifo_valid;
	wire [7:0] fifo_data;
	wire [7:0] out_byte;
	wire [3:0] oe_mask;

	// Two-stage release of the reset; the pin itself feeds no logic.
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Three flops per pin; a level counts once stages two and three agree.
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= `SFB_PIN_RST;
			s2_reg <= `SFB_PIN_RST;
			s3_reg <= `SFB_PIN_RST;
			filt_reg <= `SFB_PIN_RST;
			prev_reg <= `SFB_PIN_RST;
		end
		else
		begin
			s1_reg <= {lane3_in, lane2_in, lane1_in, lane0_in,
				sclk_in, select_n_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
			prev_reg <= filt_reg;
		end
	end

	// Edges are seen a few system clocks late; 25 MHz against the
	// 3 MHz link leaves ample margin but limits the link rate.
	assign sel = ~filt_reg[`SFB_PIN_SEL];
	assign rise = filt_reg[`SFB_PIN_SCLK]
		& ~prev_reg[`SFB_PIN_SCLK];
	assign fall = ~filt_reg[`SFB_PIN_SCLK] & prev_reg[`SFB_PIN_SCLK];
	assign lane_pins = filt_reg[`SFB_PIN_LANE3:`SFB_PIN_LANE0];

	// The shared pin is a restart only when selected as one and quad
	// operation has not claimed it as lane3.
	assign hw_rst = pause_or_restart_select_in & ~four_lane_enable_in
		& ~filt_reg[`SFB_PIN_LANE3];

	// Pause is possible only in standard or dual transfers while selected.
	assign pause_ok = sel & ~pause_or_restart_select_in
		& ~four_lane_enable_in & ~qpi_mode_out
		& (lanes_reg != `SFB_LANES_FOUR);

	assign cmd_lanes = qpi_mode_out ? `SFB_LANES_FOUR : `SFB_LANES_ONE;
	assign op_next = sfb_shl(in_sh_reg, lane_pins, cmd_lanes);
	assign in_cnt_next = in_cnt_reg + cmd_lanes;

	// A new byte leaves the FIFO at the falling edge that needs it.
	assign pop = (state_reg == ST_DATA) & sel & fall & ~paused_reg
		& ~hw_rst & (out_cnt_reg == 4'h0);
	assign out_byte = (out_cnt_reg == 4'h0)
		? (fifo_valid ? fifo_data : 8'h00) : out_sh_reg;
	assign oe_mask = (lanes_reg == `SFB_LANES_FOUR) ? 4'hf : 4'h3;

	sfb_fifo #(
		.W  (8),
		.D  (16),
		.AW (4)
	) u_fifo (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n),
		.wr_valid_in  (data_valid_in),
		.wr_data_in   (data_in),
		.wr_ready_out (data_ready_out),
		.rd_valid_out (fifo_valid),
		.rd_data_out  (fifo_data),
		.rd_ready_in  (pop)
	);

	// Main sequencer: restart first, then deselect, pause, then edges.
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_CMD;
			in_sh_reg <= 8'h00;
			in_cnt_reg <= 4'h0;
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 4'h0;
			lanes_reg <= `SFB_LANES_ONE;
			drive_reg <= 1'b0;
			paused_reg <= 1'b0;
			armed_reg <= 1'b0;
			timer_reg <= 9'h000;
			qpi_mode_out <= 1'b0;
			cmd_out <= 8'h00;
			cmd_valid_out <= 1'b0;
			busy_out <= 1'b0;
			{lane3_out, lane2_out, lane1_out, lane0_out} <= 4'h0;
			{lane3_oe_out, lane2_oe_out, lane1_oe_out,
				lane0_oe_out} <= 4'h0;
		end
		else
		begin
			cmd_valid_out <= 1'b0;
			busy_out <= hw_rst | (timer_reg > 9'h001);
			if (timer_reg != 9'h000)
				timer_reg <= timer_reg - 9'h001;
			if (hw_rst)
			begin
				// Back to the power-on state whatever else is happening.
				state_reg <= ST_CMD;
				in_cnt_reg <= 4'h0;
				out_cnt_reg <= 4'h0;
				lanes_reg <= `SFB_LANES_ONE;
				drive_reg <= 1'b0;
				paused_reg <= 1'b0;
				armed_reg <= 1'b0;
				timer_reg <= 9'h000;
				qpi_mode_out <= 1'b0;
			end
			else if (!sel)
			begin
				// Deselect ends any transfer, paused or not.
				state_reg <= ST_CMD;
				in_cnt_reg <= 4'h0;
				out_cnt_reg <= 4'h0;
				lanes_reg <= `SFB_LANES_ONE;
				drive_reg <= 1'b0;
				paused_reg <= 1'b0;
			end
			else if (!pause_ok)
				paused_reg <= 1'b0;
			else if (!filt_reg[`SFB_PIN_SCLK])
				// Sampling only with the clock low gives both the
				// immediate and the next-falling-edge cases.
				paused_reg <= ~filt_reg[`SFB_PIN_LANE3];

			if (!hw_rst && sel && !paused_reg && rise
				&& state_reg == ST_CMD)
			begin
				// Opcode bits arrive on rising edges, top bit first.
				in_sh_reg <= op_next;
				in_cnt_reg <= in_cnt_next;
				if (in_cnt_next == 4'h8)
				begin
					state_reg <= ST_SKIP;
					if (busy_out)
						armed_reg <= 1'b0;
					else
					begin
						cmd_out <= op_next;
						cmd_valid_out <= 1'b1;
						armed_reg <= (op_next == `SFB_OP_RST_ENABLE);
						case (op_next)
							`SFB_OP_ENTER_QPI:
								if (four_lane_enable_in)
									qpi_mode_out <= 1'b1;
							`SFB_OP_EXIT_QPI:
								qpi_mode_out <= 1'b0;
							`SFB_OP_RST_DO:
								if (armed_reg)
								begin
									qpi_mode_out <= 1'b0;
									timer_reg <= RST_CYC_C;
								end
							`SFB_OP_DUAL_OUT, `SFB_OP_DUAL_IO:
							begin
								state_reg <= ST_DATA;
								lanes_reg <= qpi_mode_out
									? `SFB_LANES_FOUR : `SFB_LANES_TWO;
							end
							`SFB_OP_QUAD_OUT, `SFB_OP_QUAD_IO,
							`SFB_OP_QUAD_WORD, `SFB_OP_QUAD_OCT:
								if (four_lane_enable_in)
								begin
									state_reg <= ST_DATA;
									lanes_reg <= `SFB_LANES_FOUR;
								end
							default:
								state_reg <= ST_SKIP;
						endcase
					end
				end
			end

			if (!hw_rst && sel && !paused_reg && fall
				&& state_reg == ST_DATA)
			begin
				// Each falling edge opens a cycle and presents new bits.
				drive_reg <= 1'b1;
				out_sh_reg <= sfb_shl(out_byte, 4'h0, lanes_reg);
				out_cnt_reg <= ((out_cnt_reg == 4'h0) ? 4'h8
					: out_cnt_reg) - lanes_reg;
				if (lanes_reg == `SFB_LANES_FOUR)
					{lane3_out, lane2_out, lane1_out, lane0_out}
						<= out_byte[7:4];
				else
					{lane3_out, lane2_out, lane1_out, lane0_out}
						<= {2'b00, out_byte[7:6]};
			end

			// Lanes float outside the data phase and while paused.
			if (!hw_rst && sel && !paused_reg
				&& state_reg == ST_DATA && (drive_reg || fall))
				{lane3_oe_out, lane2_oe_out, lane1_oe_out,
					lane0_oe_out} <= oe_mask;
			else
				{lane3_oe_out, lane2_oe_out, lane1_oe_out,
					lane0_oe_out} <= 4'h0;
		end
	end
endmodule

//--- sfb_flash_bus_props.sv
// Checker for the serial flash bus front end, bound to its top module.
`timescale 1ns/1ps
`include "sfb_regs.vh"
module sfb_fbp_props (
	input wire       clk_in,                     // System clock.
	input wire       rstn_in,                    // Reset, active low.
	input wire       select_n_in,                // Select pin.
	input wire       sclk_in,                    // Serial clock pin.
	input wire       lane3_in,                   // Pause or restart pin.
	input wire       lane0_oe_out,               // Lane0 enable.
	input wire       lane1_oe_out,               // Lane1 enable.
	input wire       four_lane_enable_in,        // Quad enable.
	input wire       pause_or_restart_select_in, // Shared pin function.
	input wire [7:0] cmd_out,                    // Last opcode.
	input wire       cmd_valid_out,              // Opcode pulse.
	input wire       qpi_mode_out,               // Four-lane mode.
	input wire       busy_out                    // Commands refused.
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// Raw pin conditions; the counts below cover the synchroniser delay.
	wire hold_c = !select_n_in && !sclk_in && !lane3_in && !qpi_mode_out &&
		!pause_or_restart_select_in && !four_lane_enable_in;
	wire rst_c = pause_or_restart_select_in && !four_lane_enable_in &&
		!lane3_in;

	a_cmd_one_pulse: assert property (
		cmd_valid_out |=> !cmd_valid_out)
		else $error("opcode pulse longer than one cycle");
	a_busy_refuses: assert property (
		busy_out && $past(busy_out, 2) |-> !cmd_valid_out)
		else $error("opcode accepted while busy");
	a_qpi_needs_qe: assert property (
		$rose(qpi_mode_out) |-> $past(four_lane_enable_in))
		else $error("four-lane mode entered without quad enable");
	a_qpi_enters: assert property (
		cmd_valid_out && cmd_out == `SFB_OP_ENTER_QPI &&
		four_lane_enable_in |-> ##[0:2] qpi_mode_out)
		else $error("enter opcode did not set four-lane mode");
	a_qpi_leaves: assert property (
		cmd_valid_out && cmd_out == `SFB_OP_EXIT_QPI |-> ##[0:2] !qpi_mode_out)
		else $error("exit opcode did not clear four-lane mode");
	a_restart_wins: assert property (
		rst_c [*8] |-> busy_out && !qpi_mode_out)
		else $error("restart pin did not reset the interface");
	a_deselect_float: assert property (
		select_n_in [*8] |-> !lane0_oe_out && !lane1_oe_out)
		else $error("lanes driven while deselected");
	a_pause_float: assert property (
		hold_c [*8] |-> !lane0_oe_out && !lane1_oe_out)
		else $error("lanes driven during pause");

	// Main scenarios reached.
	c_dual: cover property (cmd_valid_out && cmd_out == `SFB_OP_DUAL_OUT);
	c_qpi: cover property ($rose(qpi_mode_out));
	c_busy: cover property ($rose(busy_out));
endmodule

bind sfb_flash_bus sfb_fbp_props u_props (.clk_in, .rstn_in, .select_n_in,
	.sclk_in, .lane3_in, .lane0_oe_out, .lane1_oe_out, .four_lane_enable_in,
	.pause_or_restart_select_in, .cmd_out, .cmd_valid_out, .qpi_mode_out,
	.busy_out);

//--- sfb_host_model.sv
// Host model: drives select, serial clock and lanes of the flash bus.
`timescale 1ns/1ps
module sfb_host_model (
	input  wire       clk_in,       // System clock that paces the host.
	input  wire [3:0] dev_val_in,   // Device lane values.
	input  wire [3:0] dev_oe_in,    // Device lane enables.
	output reg        select_n_out, // Select, active low.
	output reg        sclk_out,     // Serial clock.
	output wire [3:0] lane_out      // Resolved lane levels.
);
	reg       cpol_reg; // Idle clock level, 1 for mode 3.
	reg [3:0] hv_reg;   // Host lane values.
	reg [3:0] hoe_reg;  // Host lane enables.
	integer   i;

	// A lane nobody drives shows the inverse of the host's last value.
	assign lane_out = (dev_oe_in & dev_val_in) |
		(~dev_oe_in & ~(hoe_reg ^ hv_reg));

	// Idle: deselected, clock low, guard and pause pins high.
	initial
	begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		cpol_reg = 1'b0;
		hv_reg = 4'hc;
		hoe_reg = 4'hd;
	end

	// Half of a 320 ns serial clock period.
	task half;
	begin
		repeat (4) @(negedge clk_in);
	end
	endtask

	// Park the clock at its idle level before select falls.
	task open_frame(input m3);
	begin
		cpol_reg = m3;
		sclk_out = m3;
		half;
		select_n_out = 1'b0;
		half;
	end
	endtask

	// Lanes change with the fall and are sampled by the device on the rise.
	task tick(input [3:0] v);
	begin
		sclk_out = 1'b0;
		hv_reg = v;
		half;
		sclk_out = 1'b1;
		half;
	end
	endtask

	// Opcode on four lanes in two clocks or on lane0 in eight, top bit first.
	task send_op(input [7:0] c, input q);
	begin
		hoe_reg = q ? 4'hf : 4'hd;
		if (q)
		begin
			tick(c[7:4]);
			tick(c[3:0]);
		end
		else
			for (i = 7; i >= 0; i = i - 1)
				tick({3'b110, c[i]});
	end
	endtask

	// Release the read lanes, clock once and sample just before next fall.
	task grp(input [3:0] oe, output [3:0] s);
	begin
		hoe_reg = oe;
		sclk_out = 1'b0;
		half;
		sclk_out = 1'b1;
		half;
		s = lane_out;
	end
	endtask

	// Return the clock to its idle level, then deselect.
	task close_frame;
	begin
		if (!cpol_reg && sclk_out)
		begin
			sclk_out = 1'b0;
			half;
		end
		select_n_out = 1'b1;
		hoe_reg = 4'hd;
		hv_reg = 4'hc;
		half;
		half;
	end
	endtask
endmodule

//--- test_sfb_flash_bus.sv
// Self-checking testbench for the serial flash bus front end.
`timescale 1ns/1ps
`include "sfb_regs.vh"
module test_sfb_flash_bus;
	reg        clk_in;
	reg        rstn_in;
	reg        qe_reg;
	reg        prs_reg;
	reg        dv_reg;
	reg  [7:0] din_reg;
	reg  [7:0] e;
	reg  [3:0] s;
	wire       sel_n;
	wire       sclk;
	wire [3:0] pin;
	wire [3:0] dval;
	wire [3:0] doe;
	wire       drdy;
	wire [7:0] cmd;
	wire       cmd_v;
	wire       four_lane_instruction_mode;
	wire       busy;
	integer    n_mismatch;
	integer    checks;
	integer    ncmd;
	integer    nbusy;
	integer    n0;
	integer    k;
	integer    acc;

	sfb_flash_bus DUT (.clk_in(clk_in), .rstn_in(rstn_in),
		.select_n_in(sel_n), .sclk_in(sclk), .lane0_in(pin[0]),
		.lane1_in(pin[1]), .lane2_in(pin[2]), .lane3_in(pin[3]),
		.lane0_out(dval[0]), .lane1_out(dval[1]), .lane2_out(dval[2]),
		.lane3_out(dval[3]), .lane0_oe_out(doe[0]), .lane1_oe_out(doe[1]),
		.lane2_oe_out(doe[2]), .lane3_oe_out(doe[3]),
		.four_lane_enable_in(qe_reg), .pause_or_restart_select_in(prs_reg),
		.data_valid_in(dv_reg), .data_in(din_reg), .data_ready_out(drdy),
		.cmd_out(cmd), .cmd_valid_out(cmd_v), .qpi_mode_out(four_lane_instruction_mode),
		.busy_out(busy));
	sfb_host_model host (.clk_in(clk_in), .dev_val_in(dval),
		.dev_oe_in(doe), .select_n_out(sel_n), .sclk_out(sclk),
		.lane_out(pin));

	// 25 MHz clock; accepted opcodes and busy cycles are counted.
	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		if (cmd_v === 1'b1) ncmd = ncmd + 1;
		if (busy === 1'b1) nbusy = nbusy + 1;
	end

	////////////////////////////////////////////////////////////////////////
	function [7:0] bv(input [3:0] n);
		bv = {n, ~n};
	endfunction
	task wt(input integer n);
		repeat (n) @(negedge clk_in);
	endtask
	task chk(input [8*8:1] nm, input [7:0] seen, input [7:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0s exp %h got %h", nm, exp, seen);
		end
	end
	endtask
	task frame(input [7:0] c, input q);
	begin
		host.open_frame(1'b0);
		host.send_op(c, q);
		host.close_frame;
	end
	endtask
	task conclude;
	begin
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Fill the FIFO until it refuses, read one byte dual in mode 3, then
	// drain the rest on four lanes in mode 0, then read 00 from the empty FIFO.
	task t_fifo;
	begin
		acc = 0;
		dv_reg = 1'b1;
		repeat (20)
		begin
			din_reg = bv(acc[3:0]);
			if (drdy === 1'b1) acc = acc + 1;
			@(negedge clk_in);
		end
		dv_reg = 1'b0;
		chk("filled", acc[7:0], 8'h10);
		chk("ready", drdy, 8'h00);
		host.open_frame(1'b1);
		host.send_op(`SFB_OP_DUAL_OUT, 1'b0);
		e = bv(4'h0);
		for (k = 3; k >= 0; k = k - 1)
		begin
			host.grp(4'hc, s);
			chk("dual", s[1:0], e[2*k+:2]);
		end
		host.close_frame;
		chk("cmd", cmd, `SFB_OP_DUAL_OUT);
		qe_reg = 1'b1;
		host.open_frame(1'b0);
		host.send_op(`SFB_OP_QUAD_OUT, 1'b0);
		for (k = 1; k <= 16; k = k + 1)
		begin
			e = (k < 16) ? bv(k[3:0]) : 8'h00;
			host.grp(4'h0, s);
			chk("quad_hi", s, e[7:4]);
			host.grp(4'h0, s);
			chk("quad_lo", s, e[3:0]);
		end
		host.close_frame;
		chk("ready", drdy, 8'h01);
		qe_reg = 1'b0;
		$display("t_fifo done");
	end
	endtask

	// Four-lane instruction mode: refused without quad enable.
	task t_qpi;
	begin
		frame(`SFB_OP_ENTER_QPI, 1'b0);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		qe_reg = 1'b1;
		frame(`SFB_OP_ENTER_QPI, 1'b0);
		chk("qpi", four_lane_instruction_mode, 8'h01);
		frame(`SFB_OP_EXIT_QPI, 1'b1);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		chk("cmd", cmd, `SFB_OP_EXIT_QPI);
		$display("t_qpi done");
	end
	endtask

	// Software reset from four-lane mode, refusal while recovering, and a
	// sequence broken by another opcode.
	task t_swrst;
	begin
		frame(`SFB_OP_ENTER_QPI, 1'b0);
		frame(`SFB_OP_RST_ENABLE, 1'b1);
		nbusy = 0;
		frame(`SFB_OP_RST_DO, 1'b1);
		chk("busy", busy, 8'h01);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		n0 = ncmd;
		frame(`SFB_OP_ENTER_QPI, 1'b0);
		chk("refused", ncmd - n0, 8'h00);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		k = 0;
		while (busy === 1'b1 && k < 400)
		begin
			wt(1);
			k = k + 1;
		end
		chk("busyend", busy, 8'h00);
		chk("busylen", nbusy >= 248 && nbusy <= 252, 8'h01);
		frame(`SFB_OP_RST_ENABLE, 1'b0);
		frame(`SFB_OP_DUAL_OUT, 1'b0);
		frame(`SFB_OP_RST_DO, 1'b0);
		chk("busy", busy, 8'h00);
		qe_reg = 1'b0;
		$display("t_swrst done");
	end
	endtask

	// Pause in mid dual read: lanes float, clock ignored, state kept.
	task t_pause;
	begin
		din_reg = bv(4'h5);
		dv_reg = 1'b1;
		wt(1);
		dv_reg = 1'b0;
		e = bv(4'h5);
		host.open_frame(1'b0);
		host.send_op(`SFB_OP_DUAL_OUT, 1'b0);
		host.grp(4'hc, s);
		chk("dual", s[1:0], e[7:6]);
		host.sclk_out = 1'b0;
		host.half;
		host.hv_reg[3] = 1'b0;
		// Select stays low for the whole pause, as the host must keep it.
		wt(10);
		chk("oe", doe, 8'h00);
		host.sclk_out = 1'b1;
		host.half;
		host.sclk_out = 1'b0;
		host.half;
		host.hv_reg[3] = 1'b1;
		host.half;
		host.sclk_out = 1'b1;
		host.half;
		chk("resume", pin[1:0], e[5:4]);
		host.grp(4'hc, s);
		chk("resume", s[1:0], e[3:2]);
		host.close_frame;
		$display("t_pause done");
	end
	endtask

	// Shared pin as restart: ignored with quad enable, else it wins.
	task t_restart;
	begin
		qe_reg = 1'b1;
		frame(`SFB_OP_ENTER_QPI, 1'b0);
		prs_reg = 1'b1;
		host.hv_reg[3] = 1'b0;
		wt(12);
		chk("busy", busy, 8'h00);
		chk("qpi", four_lane_instruction_mode, 8'h01);
		qe_reg = 1'b0;
		// Restart must stand low for more than 1 us: 26 cycles of 40 ns.
		wt(26);
		chk("busy", busy, 8'h01);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		host.hv_reg[3] = 1'b1;
		wt(12);
		chk("busy", busy, 8'h00);
		prs_reg = 1'b0;
		$display("t_restart done");
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset for 8 cycles, then the scenarios in order.
	initial
	begin
		rstn_in = 1'b0;
		qe_reg = 1'b0;
		prs_reg = 1'b0;
		dv_reg = 1'b0;
		din_reg = 8'h00;
		n_mismatch = 0;
		checks = 0;
		ncmd = 0;
		nbusy = 0;
		wt(8);
		rstn_in = 1'b1;
		wt(4);
		chk("qpi", four_lane_instruction_mode, 8'h00);
		chk("busy", busy, 8'h00);
		t_fifo;
		t_qpi;
		t_swrst;
		t_pause;
		t_restart;
		conclude;
	end

	// The scenarios need well under 1 ms; a hang ends the run here.
	initial
	begin
		#1000000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
endmodule
